// file: design/apb_ctl_regs.sv
// apb slave holding the software registers of the control bank
`timescale 1ns/1ps
module apb_ctl_regs
    import ctl_bank_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [9:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // register values
    cfg_if.regs cfg
);
    logic [7:0] up_r, down_r, lo_r, mid_r, hi_r, line_r, len_r, stuff_r;
    logic [7:0] idx;
    logic hit;
    logic [7:0] rd;
    logic wr;

    // word index decode
    assign idx = i_paddr[9:2];
    assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0];

    // read mux and map check
    always_comb
    begin
        hit = 1'b1;
        rd = 8'h00;
        unique case (idx)
            IDX_UP_CODE: rd = up_r;
            IDX_DOWN_CODE: rd = down_r;
            IDX_CLEAR_LOW: rd = lo_r;
            IDX_CLEAR_MID: rd = mid_r;
            IDX_CLEAR_HIGH: rd = hi_r;
            IDX_LINE_CTRL: rd = line_r;
            IDX_CODE_LEN: rd = len_r;
            IDX_FORCE_STUFF: rd = {6'h00, stuff_r[1:0]};
            default: hit = 1'b0;
        endcase
    end

    // register writes, byte lane 0 only
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            up_r <= REG_RESET;
            down_r <= REG_RESET;
            lo_r <= REG_RESET;
            mid_r <= REG_RESET;
            hi_r <= REG_RESET;
            line_r <= REG_RESET;
            len_r <= CODE_LEN_RESET;
            stuff_r <= REG_RESET;
        end
        else if (wr && hit)
        begin
            unique case (idx)
                IDX_UP_CODE: up_r <= i_pwdata[7:0];
                IDX_DOWN_CODE: down_r <= i_pwdata[7:0];
                IDX_CLEAR_LOW: lo_r <= i_pwdata[7:0];
                IDX_CLEAR_MID: mid_r <= i_pwdata[7:0];
                IDX_CLEAR_HIGH: hi_r <= i_pwdata[7:0];
                IDX_LINE_CTRL: line_r <= i_pwdata[7:0];
                IDX_CODE_LEN: len_r <= {2'b00, i_pwdata[5:0]};
                IDX_FORCE_STUFF: stuff_r <= {6'h00, i_pwdata[1:0]};
                default: ;
            endcase
        end
    end

    // read data and error registered in setup phase
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (i_psel && !i_penable)
        begin
            o_prdata <= {24'h000000, rd};
            o_pslverr <= !hit;
        end
    end

    // values to the core
    assign cfg.up_code = up_r;
    assign cfg.down_code = down_r;
    assign cfg.clear_ch = {hi_r, mid_r, lo_r};
    assign cfg.line_ctrl = line_r;
    assign cfg.code_len = len_r;
    assign cfg.force_stuff = stuff_r;
endmodule

// file: design/cfg_if.sv
// interface carrying register values from the bus slave to the bank core
`timescale 1ns/1ps
interface cfg_if;
    logic [7:0] up_code;
    logic [7:0] down_code;
    logic [23:0] clear_ch;
    logic [7:0] line_ctrl;
    logic [7:0] code_len;
    logic [7:0] force_stuff;
    modport regs (output up_code, down_code, clear_ch, line_ctrl, code_len, force_stuff);
    modport core (input up_code, down_code, clear_ch, line_ctrl, code_len, force_stuff);
endinterface

// file: design/code_transp_line_ctrl_regs.sv
// control bank for loop codes, transmit transparency and line interface
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module code_transp_line_ctrl_regs
    import ctl_bank_pkg::*;
#(
    parameter int CHANNELS = 24
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [9:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // formatter status, same clock
    input wire logic i_d4_mode,
    input wire logic i_yellow_tx,
    input wire logic [4:0] i_tx_channel,
    // code detector
    output logic [7:0] o_up_pattern,
    output logic [7:0] o_up_care,
    output logic [7:0] o_down_pattern,
    output logic [7:0] o_down_care,
    // formatter controls for current channel, plus the full 24-channel clear mask
    output logic o_rbs_insert,
    output logic o_bit7_stuff,
    output logic o_force_bit2_zero,
    output logic [23:0] o_clear_mask,
    // line interface
    output logic [2:0] o_build_out_sel,
    output logic o_eq_gain_limit,
    output logic o_jitter_atten_path_sel,
    output logic o_jitter_atten_depth_sel,
    output logic o_jitter_atten_disable,
    output logic o_transmitter_power_down,
    output logic o_tx_line_pos_oe,
    output logic o_tx_line_neg_oe
);
    import ctl_bank_pkg::*;

    // elaboration check: the clear decode serves exactly 24 channels
    if (CHANNELS != 24)
    begin : g_bad_channels
        $error("only 24 channels supported");
    end

    cfg_if cfg ();

    logic stuff_all;
    logic ch_clear;
    logic [7:0] len_up_r, len_down_r;

    // register file over apb
    apb_ctl_regs u_regs (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb),
        .o_prdata(o_prdata),
        .o_pslverr(o_pslverr),
        .cfg(cfg.regs)
    );

    // zero wait state slave
    assign o_pready = 1'b1;

    // don't-care mask from length field: top len+1 bits cared
    function automatic logic [7:0] care_mask(input logic [2:0] len);
        care_mask = 8'(8'hff << (3'd7 - len));
    endfunction

    // detector pattern and mask registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_up_pattern <= 8'h00;
            o_up_care <= care_mask(CODE_LEN_RESET[UP_LEN_LSB +: LEN_W]);
            o_down_pattern <= 8'h00;
            o_down_care <= care_mask(CODE_LEN_RESET[DOWN_LEN_LSB +: LEN_W]);
        end
        else
        begin
            o_up_care <= care_mask(cfg.code_len[UP_LEN_LSB +: LEN_W]);
            o_up_pattern <= cfg.up_code & care_mask(cfg.code_len[UP_LEN_LSB +: LEN_W]);
            o_down_care <= care_mask(cfg.code_len[DOWN_LEN_LSB +: LEN_W]);
            o_down_pattern <= cfg.down_code & care_mask(cfg.code_len[DOWN_LEN_LSB +: LEN_W]);
        end
    end

    // helper copies for checking
    assign len_up_r = {5'h00, cfg.code_len[UP_LEN_LSB +: LEN_W]};
    assign len_down_r = {5'h00, cfg.code_len[DOWN_LEN_LSB +: LEN_W]};

    // per-channel clear decode; channel index 0 is channel 1
    assign stuff_all = cfg.force_stuff[STUFF_A_BIT] && cfg.force_stuff[STUFF_B_BIT];
    assign ch_clear = (i_tx_channel < 5'd24) ? cfg.clear_ch[i_tx_channel] : 1'b0;

    // formatter controls
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_rbs_insert <= 1'b1;
            o_bit7_stuff <= 1'b1;
            o_force_bit2_zero <= 1'b0;
            o_clear_mask <= 24'h000000;
        end
        else
        begin
            o_rbs_insert <= !ch_clear;
            o_bit7_stuff <= stuff_all || !ch_clear;
            o_force_bit2_zero <= i_d4_mode && i_yellow_tx;
            o_clear_mask <= cfg.clear_ch;
        end
    end

    // line interface controls
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_build_out_sel <= 3'h0;
            o_eq_gain_limit <= 1'b0;
            o_jitter_atten_path_sel <= 1'b0;
            o_jitter_atten_depth_sel <= 1'b0;
            o_jitter_atten_disable <= 1'b0;
            o_transmitter_power_down <= 1'b0;
            o_tx_line_pos_oe <= 1'b0;
            o_tx_line_neg_oe <= 1'b0;
        end
        else
        begin
            o_build_out_sel <= cfg.line_ctrl[BUILD_OUT_LSB +: 3];
            o_eq_gain_limit <= cfg.line_ctrl[EQ_GAIN_BIT];
            o_jitter_atten_path_sel <= cfg.line_ctrl[JA_PATH_BIT];
            o_jitter_atten_depth_sel <= cfg.line_ctrl[JA_DEPTH_BIT];
            o_jitter_atten_disable <= cfg.line_ctrl[JA_DIS_BIT];
            o_transmitter_power_down <= cfg.line_ctrl[TX_PD_BIT];
            o_tx_line_pos_oe <= !cfg.line_ctrl[TX_PD_BIT];
            o_tx_line_neg_oe <= !cfg.line_ctrl[TX_PD_BIT];
        end
    end

    // write strobe of the apb access
    sequence s_write(logic [7:0] ix);
        i_psel && i_penable && i_pwrite && i_pstrb[0] && i_paddr[9:2] == ix;
    endsequence

    property p_up_len;
        @(posedge i_clk) disable iff (i_rst)
        ##1 o_up_care == $past(care_mask(len_up_r[2:0]));
    endproperty
    a_up_len: assert property (p_up_len) else $error("up care mask wrong");

    property p_up_msb;
        @(posedge i_clk) disable iff (i_rst)
        s_write(IDX_UP_CODE) |-> ##2 o_up_pattern[7] == $past(i_pwdata[7], 2);
    endproperty
    a_up_msb: assert property (p_up_msb) else $error("up code first bit lost");

    property p_down_low;
        @(posedge i_clk) disable iff (i_rst)
        (len_down_r != 8'd7) |=> o_down_pattern[0] == 1'b0;
    endproperty
    a_down_low: assert property (p_down_low) else $error("down code low bit kept");

    property p_len_one;
        @(posedge i_clk) disable iff (i_rst)
        (len_up_r == 8'd0) |=> o_up_care == 8'h80;
    endproperty
    a_len_one: assert property (p_len_one) else $error("length one mask wrong");

    property p_clear_ch1;
        @(posedge i_clk) disable iff (i_rst)
        s_write(IDX_CLEAR_LOW) |-> ##2 o_clear_mask[0] == $past(i_pwdata[0], 2);
    endproperty
    a_clear_ch1: assert property (p_clear_ch1) else $error("channel 1 clear wrong");

    property p_rbs;
        @(posedge i_clk) disable iff (i_rst)
        ch_clear |=> !o_rbs_insert && (o_bit7_stuff == $past(stuff_all));
    endproperty
    a_rbs: assert property (p_rbs) else $error("clear channel overwritten");

    property p_yellow;
        @(posedge i_clk) disable iff (i_rst)
        (i_d4_mode && i_yellow_tx) |=> o_force_bit2_zero;
    endproperty
    a_yellow: assert property (p_yellow) else $error("bit 2 not forced");

    property p_stuff_all;
        @(posedge i_clk) disable iff (i_rst)
        stuff_all |=> o_bit7_stuff;
    endproperty
    a_stuff_all: assert property (p_stuff_all) else $error("forced stuffing missing");

    property p_line;
        @(posedge i_clk) disable iff (i_rst)
        s_write(IDX_LINE_CTRL) |-> ##2 {o_build_out_sel, o_eq_gain_limit,
            o_jitter_atten_path_sel, o_jitter_atten_depth_sel, o_jitter_atten_disable,
            o_transmitter_power_down} == $past(i_pwdata[7:0], 2);
    endproperty
    a_line: assert property (p_line) else $error("line control mismatch");

    property p_power_down;
        @(posedge i_clk) disable iff (i_rst)
        o_transmitter_power_down |-> !o_tx_line_pos_oe && !o_tx_line_neg_oe;
    endproperty
    a_power_down: assert property (p_power_down) else $error("line driven in power down");

    // line control write, then two edges until the outputs follow
    sequence s_line_settled;
        s_write(IDX_LINE_CTRL) ##2 1'b1;
    endsequence

    property p_up_low;
        @(posedge i_clk) disable iff (i_rst)
        (len_up_r != 8'd7) |=> o_up_pattern[0] == 1'b0;
    endproperty
    a_up_low: assert property (p_up_low) else $error("up code low bit kept");

    property p_down_len;
        @(posedge i_clk) disable iff (i_rst)
        ##1 o_down_care == $past(care_mask(len_down_r[2:0]));
    endproperty
    a_down_len: assert property (p_down_len) else $error("down care mask wrong");

    property p_down_msb;
        @(posedge i_clk) disable iff (i_rst)
        s_write(IDX_DOWN_CODE) |-> ##2 o_down_pattern[7] == $past(i_pwdata[7], 2);
    endproperty
    a_down_msb: assert property (p_down_msb) else $error("down code first bit lost");

    property p_down_len_one;
        @(posedge i_clk) disable iff (i_rst)
        (len_down_r == 8'd0) |=> o_down_care == 8'h80;
    endproperty
    a_down_len_one: assert property (p_down_len_one) else $error("down length one wrong");

    property p_up_len_eight;
        @(posedge i_clk) disable iff (i_rst)
        (len_up_r == 8'd7) |=> o_up_care == 8'hff && o_up_pattern == $past(cfg.up_code);
    endproperty
    a_up_len_eight: assert property (p_up_len_eight) else $error("up length eight wrong");

    property p_down_len_eight;
        @(posedge i_clk) disable iff (i_rst)
        (len_down_r == 8'd7) |=> o_down_care == 8'hff && o_down_pattern == $past(cfg.down_code);
    endproperty
    a_down_len_eight: assert property (p_down_len_eight) else $error("down length eight bad");

    property p_clear_channel_last_clear;
        @(posedge i_clk) disable iff (i_rst)
        s_write(IDX_CLEAR_HIGH) |-> ##2 o_clear_mask[23] == $past(i_pwdata[7], 2);
    endproperty
    a_clear_channel_last_clear: assert property (p_clear_channel_last_clear) else $error("channel 24 clear wrong");

    property p_clear_mid;
        @(posedge i_clk) disable iff (i_rst)
        s_write(IDX_CLEAR_MID) |-> ##2 o_clear_mask[15:8] == $past(i_pwdata[7:0], 2);
    endproperty
    a_clear_mid: assert property (p_clear_mid) else $error("middle clear bits wrong");

    property p_not_clear;
        @(posedge i_clk) disable iff (i_rst)
        !ch_clear |=> o_rbs_insert && o_bit7_stuff;
    endproperty
    a_not_clear: assert property (p_not_clear) else $error("normal channel not overwritten");

    property p_far_channel;
        @(posedge i_clk) disable iff (i_rst)
        (i_tx_channel > 5'd23) |=> o_rbs_insert && o_bit7_stuff;
    endproperty
    a_far_channel: assert property (p_far_channel) else $error("spare slot taken as clear");

    property p_yellow_off;
        @(posedge i_clk) disable iff (i_rst)
        !(i_d4_mode && i_yellow_tx) |=> !o_force_bit2_zero;
    endproperty
    a_yellow_off: assert property (p_yellow_off) else $error("bit 2 forced without alarm");

    property p_stuff_clear;
        @(posedge i_clk) disable iff (i_rst)
        (ch_clear && !stuff_all) |=> !o_bit7_stuff;
    endproperty
    a_stuff_clear: assert property (p_stuff_clear) else $error("clear channel stuffed");

    property p_build_out;
        @(posedge i_clk) disable iff (i_rst)
        s_line_settled |-> o_build_out_sel == $past(i_pwdata[BUILD_OUT_LSB +: 3], 2);
    endproperty
    a_build_out: assert property (p_build_out) else $error("build-out select wrong");

    property p_eq_limit;
        @(posedge i_clk) disable iff (i_rst)
        s_line_settled |-> o_eq_gain_limit == $past(i_pwdata[EQ_GAIN_BIT], 2);
    endproperty
    a_eq_limit: assert property (p_eq_limit) else $error("equalizer limit wrong");

    property p_ja_path;
        @(posedge i_clk) disable iff (i_rst)
        s_line_settled |-> o_jitter_atten_path_sel == $past(i_pwdata[JA_PATH_BIT], 2);
    endproperty
    a_ja_path: assert property (p_ja_path) else $error("attenuator path wrong");

    property p_ja_depth;
        @(posedge i_clk) disable iff (i_rst)
        s_line_settled |-> o_jitter_atten_depth_sel == $past(i_pwdata[JA_DEPTH_BIT], 2);
    endproperty
    a_ja_depth: assert property (p_ja_depth) else $error("attenuator depth wrong");

    property p_ja_disable;
        @(posedge i_clk) disable iff (i_rst)
        s_line_settled |-> o_jitter_atten_disable == $past(i_pwdata[JA_DIS_BIT], 2);
    endproperty
    a_ja_disable: assert property (p_ja_disable) else $error("attenuator disable wrong");

    property p_line_oe;
        @(posedge i_clk) disable iff (i_rst)
        s_line_settled |-> o_tx_line_pos_oe != $past(i_pwdata[TX_PD_BIT], 2)
            && o_tx_line_neg_oe != $past(i_pwdata[TX_PD_BIT], 2);
    endproperty
    a_line_oe: assert property (p_line_oe) else $error("line enable wrong");
endmodule

// file: design/ctl_bank_pkg.sv
// package with register map, field positions and reset values of the control bank
package ctl_bank_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] IDX_UP_CODE = 8'h14;
    localparam logic [7:0] IDX_DOWN_CODE = 8'h15;
    localparam logic [7:0] IDX_CLEAR_LOW = 8'h39;
    localparam logic [7:0] IDX_CLEAR_MID = 8'h3a;
    localparam logic [7:0] IDX_CLEAR_HIGH = 8'h3b;
    localparam logic [7:0] IDX_LINE_CTRL = 8'h7c;
    localparam logic [7:0] IDX_CODE_LEN = 8'h80;
    localparam logic [7:0] IDX_FORCE_STUFF = 8'h81;
    localparam int UP_LEN_LSB = 3;
    localparam int DOWN_LEN_LSB = 0;
    localparam int LEN_W = 3;
    localparam int BUILD_OUT_LSB = 5;
    localparam int EQ_GAIN_BIT = 4;
    localparam int JA_PATH_BIT = 3;
    localparam int JA_DEPTH_BIT = 2;
    localparam int JA_DIS_BIT = 1;
    localparam int TX_PD_BIT = 0;
    localparam int STUFF_A_BIT = 0;
    localparam int STUFF_B_BIT = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CODE_LEN_RESET = 8'h3f;
endpackage

// file: verification/code_transp_line_ctrl_regs_tb.sv
// self-checking bench for the loop code, transparency and line control bank
`timescale 1ns/1ps
module code_transp_line_ctrl_regs_tb;
    import ctl_bank_pkg::*;
    // design inputs, all set at time zero
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [9:0] i_paddr = 10'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [3:0] i_pstrb = 4'h0;
    logic i_d4_mode = 1'b0;
    logic i_yellow_tx = 1'b0;
    logic [4:0] i_tx_channel = 5'h00;
    // design outputs
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [7:0] o_up_pattern;
    logic [7:0] o_up_care;
    logic [7:0] o_down_pattern;
    logic [7:0] o_down_care;
    logic o_rbs_insert;
    logic o_bit7_stuff;
    logic o_force_bit2_zero;
    logic [23:0] o_clear_mask;
    logic [2:0] o_build_out_sel;
    logic o_eq_gain_limit;
    logic o_jitter_atten_path_sel;
    logic o_jitter_atten_depth_sel;
    logic o_jitter_atten_disable;
    logic o_transmitter_power_down;
    logic o_tx_line_pos_oe;
    logic o_tx_line_neg_oe;
    // bookkeeping and register model, order: up, down, low, mid, high, line, length, force
    int failures = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] mdl [8];
    logic [9:0] addr_tbl [8] = '{10'h050, 10'h054, 10'h0e4, 10'h0e8, 10'h0ec, 10'h1f0,
                                 10'h200, 10'h204};
    logic [7:0] msk [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h03};

    // 25 MHz clock
    always #20 i_clk = ~i_clk;

    code_transp_line_ctrl_regs #(.CHANNELS(24)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_d4_mode(i_d4_mode), .i_yellow_tx(i_yellow_tx), .i_tx_channel(i_tx_channel),
        .o_up_pattern(o_up_pattern), .o_up_care(o_up_care), .o_down_pattern(o_down_pattern),
        .o_down_care(o_down_care), .o_rbs_insert(o_rbs_insert), .o_bit7_stuff(o_bit7_stuff),
        .o_force_bit2_zero(o_force_bit2_zero), .o_clear_mask(o_clear_mask),
        .o_build_out_sel(o_build_out_sel), .o_eq_gain_limit(o_eq_gain_limit),
        .o_jitter_atten_path_sel(o_jitter_atten_path_sel),
        .o_jitter_atten_depth_sel(o_jitter_atten_depth_sel),
        .o_jitter_atten_disable(o_jitter_atten_disable),
        .o_transmitter_power_down(o_transmitter_power_down),
        .o_tx_line_pos_oe(o_tx_line_pos_oe), .o_tx_line_neg_oe(o_tx_line_neg_oe));

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic close_out();
        if (failures == 0 && check_count > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access held until pready at a rising edge
    task automatic apb(input logic wr, input logic [9:0] addr, input logic [7:0] wd,
                       input logic stb, output logic [31:0] rdata, output logic rerr);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= {24'h00_0000, wd};
        i_pstrb <= {3'b000, stb};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 20);
        check(o_pready, 1'b1, "pready");
        rdata = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // write a mapped register and track it in the model
    task automatic wr(input int i, input logic [7:0] v);
        apb(1'b1, addr_tbl[i], v, 1'b1, rd, err);
        check(err, 1'b0, "write error");
        mdl[i] = v;
    endtask

    // read a mapped register against the model
    task automatic rd_chk(input int i);
        apb(1'b0, addr_tbl[i], 8'h00, 1'b1, rd, err);
        check(rd, {24'h00_0000, mdl[i]}, "readback");
        check(err, 1'b0, "read error");
    endtask

    // top len+1 bits of a pattern are compared
    function automatic logic [7:0] care(input logic [2:0] k);
        return 8'hff << (3'd7 - k);
    endfunction

    // derived outputs, then every channel with random alarm inputs
    task automatic check_outs();
        logic [23:0] clr;
        logic clear;
        clr = {mdl[4], mdl[3], mdl[2]};
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check(o_up_care, care(mdl[6][5:3]), "up care");
        check(o_up_pattern, mdl[0] & care(mdl[6][5:3]), "up pattern");
        check(o_down_care, care(mdl[6][2:0]), "down care");
        check(o_down_pattern, mdl[1] & care(mdl[6][2:0]), "down pattern");
        check(o_clear_mask, clr, "clear mask");
        check(o_build_out_sel, mdl[5][7:5], "build out");
        check(o_eq_gain_limit, mdl[5][4], "eq limit");
        check(o_jitter_atten_path_sel, mdl[5][3], "ja path");
        check(o_jitter_atten_depth_sel, mdl[5][2], "ja depth");
        check(o_jitter_atten_disable, mdl[5][1], "ja disable");
        check({o_transmitter_power_down, o_tx_line_pos_oe, o_tx_line_neg_oe},
              {mdl[5][0], {2{~mdl[5][0]}}}, "power down");
        for (int ch = 0; ch < 26; ch++)
        begin
            @(posedge i_clk);
            i_tx_channel <= 5'(ch);
            i_d4_mode <= 1'($urandom);
            i_yellow_tx <= 1'($urandom);
            @(posedge i_clk);
            @(negedge i_clk);
            clear = (ch < 24) ? clr[ch] : 1'b0;
            check(o_rbs_insert, !clear, "signaling");
            check(o_bit7_stuff, !clear || (mdl[7][1:0] == 2'b11), "stuffing");
            check(o_force_bit2_zero, i_d4_mode & i_yellow_tx, "bit 2");
        end
    endtask

    // main sequence
    initial
    begin
        void'($urandom(29034));
        foreach (mdl[i]) mdl[i] = REG_RESET;
        mdl[6] = CODE_LEN_RESET;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd_chk(i);
        check_outs();
        // random contents, then readback and outputs
        repeat (3)
        begin
            for (int i = 0; i < 8; i++) wr(i, 8'($urandom) & msk[i]);
            for (int i = 0; i < 8; i++) rd_chk(i);
            check_outs();
        end
        // every code length on both detectors, walking line bits and force combos
        for (int k = 0; k < 8; k++)
        begin
            wr(6, {2'b00, 3'(k), 3'(7 - k)});
            wr(5, 8'h01 << k);
            wr(7, 8'(k & 3));
            check_outs();
        end
        // reset in mid-run returns every register and output to reset values
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (mdl[i]) mdl[i] = REG_RESET;
        mdl[6] = CODE_LEN_RESET;
        for (int i = 0; i < 8; i++) rd_chk(i);
        check_outs();
        // unmapped place refused, disabled strobe drops the write
        apb(1'b1, 10'h058, 8'h5a, 1'b1, rd, err);
        check(err, 1'b1, "unmapped write");
        apb(1'b0, 10'h058, 8'h00, 1'b1, rd, err);
        check(err, 1'b1, "unmapped read");
        check(rd, 32'h0000_0000, "unmapped data");
        apb(1'b1, addr_tbl[0], ~mdl[0], 1'b0, rd, err);
        for (int i = 0; i < 8; i++) rd_chk(i);
        close_out();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge i_clk);
        failures++;
        close_out();
    end
endmodule
